// [common/cantx_pkg.sv]
// constants, register map and carrier types for the can transmit buffer control block
package cantx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int          CANTX_ADDR_W     = 8;
    localparam int          CANTX_DATA_W     = 32;
    localparam int          CANTX_CTRL_W     = 8;
    localparam int          CANTX_MAX_BUF    = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [7:0]  CTRL_BASE_OFFS   = 8'h00;
    localparam logic [7:0]  STATUS_OFFS      = 8'h10;
    localparam logic [7:0]  MASK_OFFS        = 8'h14;

    ////////////////////////////////////////////////////////////////////////////////
    // tx_buffer_control field positions and reset value
    localparam int          CTRL_ABT_BIT     = 6;
    localparam int          CTRL_ARB_BIT     = 5;
    localparam int          CTRL_ERR_BIT     = 4;
    localparam int          CTRL_REQ_BIT     = 3;
    localparam int          CTRL_PRI_LSB     = 0;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [1:0]  PRIO_RESET       = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status layout: one nibble per buffer
    localparam int          ST_PER_BUF       = 4;
    localparam int          ST_SENT_BIT      = 0;
    localparam int          ST_ABT_BIT       = 1;
    localparam int          ST_ARB_BIT       = 2;
    localparam int          ST_ERR_BIT       = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // axi responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef logic [1:0] cantx_idx_t;
    typedef logic [1:0] cantx_prio_t;

    typedef struct packed {
        logic sent;
        logic aborted;
        logic arb_lost;
        logic bus_err;
    } cantx_ev_s;

    typedef struct packed {
        cantx_ev_s  ev;
        cantx_idx_t idx;
    } cantx_outcome_s;

    typedef struct packed {
        logic        valid;
        cantx_idx_t  idx;
        cantx_prio_t prio;
    } cantx_sel_s;

endpackage

// [design/cantx_buf_reg.sv]
// one transmit buffer: control register, outcome flags and abort request
`timescale 1ns/1ps
`default_nettype none
module cantx_buf_reg
    import cantx_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    input  wire cantx_ev_s   ev,
    output logic      [7:0]  ctrl_rd,
    output logic             send_req,
    output cantx_prio_t      prio,
    output logic             abort_req
);

    logic        req_q,   req_d;
    logic        abort_q, abort_d;
    logic        abt_q,   abt_d;
    logic        arb_q,   arb_d;
    logic        err_q,   err_d;
    cantx_prio_t prio_q,  prio_d;

    wire wr_set_req = wr_en && wr_data[CTRL_REQ_BIT];
    wire wr_queue   = wr_set_req && !req_q;
    wire wr_clr_req = wr_en && !wr_data[CTRL_REQ_BIT] && req_q;
    wire finished   = ev.sent || ev.aborted;

    // request drops only on the engine's answer; a clear by software only asks for abort
    assign req_d   = finished ? 1'b0 : (wr_set_req ? 1'b1 : req_q);
    assign abort_d = (finished || wr_set_req) ? 1'b0 : (wr_clr_req || abort_q);
    // queuing clears the flags, but a same-cycle event still sets
    assign abt_d   = ev.aborted  || (abt_q && !wr_queue);
    assign arb_d   = ev.arb_lost || (arb_q && !wr_queue);
    assign err_d   = ev.bus_err  || (err_q && !wr_queue);
    assign prio_d  = wr_en ? wr_data[CTRL_PRI_LSB +: 2] : prio_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q   <= 1'b0;
            abort_q <= 1'b0;
            abt_q   <= 1'b0;
            arb_q   <= 1'b0;
            err_q   <= 1'b0;
            prio_q  <= PRIO_RESET;
        end else begin
            req_q   <= req_d;
            abort_q <= abort_d;
            abt_q   <= abt_d;
            arb_q   <= arb_d;
            err_q   <= err_d;
            prio_q  <= prio_d;
        end
    end

    // bits 7 and 2 hold no storage
    assign ctrl_rd   = {1'b0, abt_q, arb_q, err_q, req_q, 1'b0, prio_q};
    assign send_req  = req_q;
    assign prio      = prio_q;
    assign abort_req = abort_q;

endmodule // cantx_buf_reg
`default_nettype wire

// [design/cantx_buffer_ctrl.sv]
// top of the can transmit buffer control block with axi4-lite register slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cantx_buffer_ctrl
    import cantx_pkg::*;
#(
    parameter int NUM_BUF = 3
)(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // axi4-lite write address
    input  wire logic [CANTX_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // axi4-lite write data
    input  wire logic [CANTX_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]               s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read address
    input  wire logic [CANTX_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // axi4-lite read data
    output logic      [CANTX_DATA_W-1:0]  s_axi_rdata,
    output logic      [1:0]               s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // protocol engine side
    output cantx_sel_s                    tx_sel,
    output logic      [NUM_BUF-1:0]       tx_send_request,
    output logic      [NUM_BUF-1:0]       tx_abort_req,
    input  wire cantx_outcome_s           eng_outcome,
    // interrupt
    output logic                          irq
);

    localparam int ST_W = ST_PER_BUF * NUM_BUF;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode shared by the read and write paths

    function automatic logic ctrl_hit(input logic [CANTX_ADDR_W-1:0] a);
        return (a[1:0] == 2'h0)
            && (a >= CTRL_BASE_OFFS)
            && ((a - CTRL_BASE_OFFS) < CANTX_ADDR_W'(4 * NUM_BUF));
    endfunction

    function automatic cantx_idx_t ctrl_idx(input logic [CANTX_ADDR_W-1:0] a);
        logic [CANTX_ADDR_W-1:0] rel;
        rel = a - CTRL_BASE_OFFS;
        return rel[3:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data are taken independently and held

    logic                    aw_have_q;
    logic                    w_have_q;
    logic [CANTX_ADDR_W-1:0] awaddr_q;
    logic [CANTX_DATA_W-1:0] wdata_q;
    logic [3:0]              wstrb_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire b_fire  = bvalid_q && s_axi_bready;
    // one write is performed once both halves are held and no response is waiting
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;

    wire        wr_ctrl_hit   = ctrl_hit(awaddr_q);
    wire        wr_status_hit = (awaddr_q == STATUS_OFFS);
    wire        wr_mask_hit   = (awaddr_q == MASK_OFFS);
    wire        wr_mapped     = wr_ctrl_hit || wr_status_hit || wr_mask_hit;
    wire cantx_idx_t wr_idx   = ctrl_idx(awaddr_q);

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (aw_fire) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (w_fire) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (b_fire) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // transmit buffers

    logic [NUM_BUF-1:0][7:0] buf_ctrl;
    logic [NUM_BUF-1:0][1:0] buf_prio;
    logic [NUM_BUF-1:0]      buf_req;
    logic [NUM_BUF-1:0]      buf_abort;
    cantx_ev_s [NUM_BUF-1:0] buf_ev;

    for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
        // the control byte sits in lane 0; other lanes are ignored
        wire buf_wr = wr_fire && wr_ctrl_hit && (wr_idx == cantx_idx_t'(i)) && wstrb_q[0];
        // outcomes for a buffer that is not queued are dropped
        wire ev_hit = (eng_outcome.idx == cantx_idx_t'(i)) && buf_req[i];
        assign buf_ev[i] = ev_hit ? eng_outcome.ev : '0;

        cantx_buf_reg u_buf (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .wr_en     (buf_wr),
            .wr_data   (wdata_q[7:0]),
            .ev        (buf_ev[i]),
            .ctrl_rd   (buf_ctrl[i]),
            .send_req  (buf_req[i]),
            .prio      (buf_prio[i]),
            .abort_req (buf_abort[i])
        );
    end

    // a buffer waiting for its abort is not offered again
    wire [NUM_BUF-1:0] sel_pending = buf_req & ~buf_abort;

    cantx_prio_sel #(
        .NUM_BUF (NUM_BUF)
    ) u_sel (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pending (sel_pending),
        .prio    (buf_prio),
        .sel     (tx_sel)
    );

    assign tx_send_request = buf_req;
    assign tx_abort_req    = buf_abort;

    ////////////////////////////////////////////////////////////////////////////////
    // read channel

    logic                    rvalid_q;
    logic [CANTX_DATA_W-1:0] rdata_q;
    logic [1:0]              rresp_q;

    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire r_fire  = rvalid_q && s_axi_rready;

    wire             rd_ctrl_hit   = ctrl_hit(s_axi_araddr);
    wire             rd_status_hit = (s_axi_araddr == STATUS_OFFS);
    wire             rd_mask_hit   = (s_axi_araddr == MASK_OFFS);
    wire             rd_mapped     = rd_ctrl_hit || rd_status_hit || rd_mask_hit;
    wire cantx_idx_t rd_idx        = ctrl_idx(s_axi_araddr);

    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;

    wire [7:0]              rd_ctrl_byte = buf_ctrl[rd_idx];
    wire [CANTX_DATA_W-1:0] rd_word =
        rd_ctrl_hit   ? {{(CANTX_DATA_W-8){1'b0}}, rd_ctrl_byte} :
        rd_status_hit ? {{(CANTX_DATA_W-ST_W){1'b0}}, status_q}  :
        rd_mask_hit   ? {{(CANTX_DATA_W-ST_W){1'b0}}, mask_q}    :
                        '0;

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (r_fire) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    logic [ST_W-1:0] st_set;
    logic            irq_q;

    always_comb begin
        st_set = '0;
        for (int i = 0; i < NUM_BUF; i++) begin
            st_set[ST_PER_BUF*i + ST_SENT_BIT] = buf_ev[i].sent;
            st_set[ST_PER_BUF*i + ST_ABT_BIT]  = buf_ev[i].aborted;
            st_set[ST_PER_BUF*i + ST_ARB_BIT]  = buf_ev[i].arb_lost;
            st_set[ST_PER_BUF*i + ST_ERR_BIT]  = buf_ev[i].bus_err;
        end
    end

    // read-to-clear; an event in the clearing cycle survives
    wire             st_clr    = rd_fire && rd_status_hit;
    wire [ST_W-1:0]  status_d  = st_set | (st_clr ? '0 : status_q);
    wire [15:0]      mask_wide = {wdata_q[15:8] & {8{wstrb_q[1]}}, wdata_q[7:0] & {8{wstrb_q[0]}}};
    wire [15:0]      mask_keep = {{8{!wstrb_q[1]}}, {8{!wstrb_q[0]}}};
    wire [15:0]      mask_cur  = {{(16-ST_W){1'b0}}, mask_q};
    wire [15:0]      mask_new  = mask_wide | (mask_cur & mask_keep);
    wire             mask_wr   = wr_fire && wr_mask_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
            mask_q   <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q    <= |(status_d & (mask_wr ? mask_new[ST_W-1:0] : mask_q));
            if (mask_wr) begin
                mask_q <= mask_new[ST_W-1:0];
            end
        end
    end

    assign irq = irq_q;

endmodule // cantx_buffer_ctrl
`default_nettype wire

// [design/cantx_prio_sel.sv]
// picks the pending buffer that the protocol engine should send next
`timescale 1ns/1ps
`default_nettype none
module cantx_prio_sel
    import cantx_pkg::*;
#(
    parameter int NUM_BUF = 3
)(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic        [NUM_BUF-1:0]  pending,
    input  wire logic [NUM_BUF-1:0][1:0]    prio,
    output cantx_sel_s                      sel
);

    cantx_sel_s best;
    cantx_sel_s sel_q;

    // higher level first; on equal level the higher buffer number wins
    always_comb begin
        best = '0;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (pending[i] && (!best.valid || prio[i] >= best.prio)) begin
                best.valid = 1'b1;
                best.idx   = cantx_idx_t'(i);
                best.prio  = prio[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= '0;
        end else begin
            sel_q <= best;
        end
    end

    // priority only orders buffers; the identifier path never sees it
    assign sel = sel_q;

endmodule // cantx_prio_sel
`default_nettype wire

// [test/cantx_buffer_ctrl_asserts.sv]
// concurrent checks on the ports of the can transmit buffer control top
`timescale 1ns/1ps
`default_nettype none
module cantx_buffer_ctrl_asserts
    import cantx_pkg::*;
#(
    parameter int NUM_BUF = 3
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    input  wire logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    input  wire logic                s_axi_wready,
    input  wire logic [1:0]          s_axi_bresp,
    input  wire logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    input  wire logic                s_axi_arready,
    input  wire logic [31:0]         s_axi_rdata,
    input  wire logic [1:0]          s_axi_rresp,
    input  wire logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire cantx_sel_s          tx_sel,
    input  wire logic [NUM_BUF-1:0]  tx_send_request,
    input  wire logic [NUM_BUF-1:0]  tx_abort_req,
    input  wire cantx_outcome_s      eng_outcome,
    input  wire logic                irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire w_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ar_hs  = s_axi_arvalid && s_axi_arready;
    wire ev_ok  = (eng_outcome.idx < NUM_BUF) && tx_send_request[eng_outcome.idx];
    // selection is registered on buffer state, so compare with last cycle's state
    logic [NUM_BUF-1:0] req_q;
    logic [NUM_BUF-1:0] abt_q;
    always_ff @(posedge aclk) begin
        req_q <= tx_send_request;
        abt_q <= tx_abort_req;
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_sel_pending: assert property (tx_sel.valid
        |-> req_q[tx_sel.idx] && !abt_q[tx_sel.idx]) else $error("selected buffer not pending");
    chk_done_ends_req: assert property ((eng_outcome.ev.sent
        || eng_outcome.ev.aborted) && ev_ok
        |=> !tx_send_request[$past(eng_outcome.idx)]) else $error("request kept after end");
    chk_arb_keeps_req: assert property ((eng_outcome.ev.arb_lost
        || eng_outcome.ev.bus_err)
        && !eng_outcome.ev.sent && !eng_outcome.ev.aborted && ev_ok
        |=> tx_send_request[$past(eng_outcome.idx)]) else $error("request lost on retry");
    chk_abort_has_req: assert property ((tx_abort_req & ~tx_send_request) == '0)
        else $error("abort without request");
    chk_write_queues: assert property (w_both && s_axi_awaddr == CTRL_BASE_OFFS
        && s_axi_wdata[CTRL_REQ_BIT] && s_axi_wstrb[0] |-> ##[1:3] tx_send_request[0])
        else $error("write did not queue");
    chk_ctrl_gaps_zero: assert property (ar_hs && s_axi_araddr < 8'(4 * NUM_BUF)
        |=> s_axi_rdata[7] == 1'b0 && s_axi_rdata[2] == 1'b0 && s_axi_rdata[31:8] == '0)
        else $error("unused control bits not zero");
    chk_rd_answer: assert property (ar_hs |=> s_axi_rvalid) else $error("read not answered");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    cov_sent: cover property (eng_outcome.ev.sent && ev_ok);
    cov_abort: cover property (eng_outcome.ev.aborted && ev_ok);
    cov_irq: cover property ($rose(irq));
endmodule // cantx_buffer_ctrl_asserts
bind cantx_buffer_ctrl cantx_buffer_ctrl_asserts #(.NUM_BUF(NUM_BUF)) cantx_chk_i (.*);
`default_nettype wire

// [test/cantx_engine_model.sv]
// behavioural protocol engine: reports outcomes on command, answers aborts
`timescale 1ns/1ps
`default_nettype none
module cantx_engine_model
    import cantx_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            go,
    input  wire cantx_outcome_s  cmd,
    input  wire logic [3:0]      dly,
    input  wire logic [2:0]      abort_req,
    output cantx_outcome_s       eng_outcome
);
    logic [3:0]      cnt_q;
    cantx_outcome_s  job_q;
    wire cantx_idx_t abort_idx = abort_req[0] ? 2'h0 : (abort_req[1] ? 2'h1 : 2'h2);
    // each branch drives the outcome once; ev order is sent, aborted, arb lost, bus error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q       <= 4'h0;
            job_q       <= '0;
            eng_outcome <= '0;
        end else if (go) begin
            job_q       <= cmd;
            cnt_q       <= dly;
            eng_outcome <= '0;
        end else if (cnt_q != 4'h0) begin
            cnt_q       <= cnt_q - 4'h1;
            // commanded outcome after a variable bus time
            eng_outcome <= (cnt_q == 4'h1) ? job_q : '0;
        end else if (abort_req != 3'h0 && eng_outcome.ev == '0) begin
            eng_outcome <= {4'b0100, abort_idx};
        end else begin
            eng_outcome <= '0;
        end
    end
endmodule // cantx_engine_model
`default_nettype wire

// [test/test_cantx_buffer_ctrl.sv]
// self-checking bench for the can transmit buffer control block
`timescale 1ns/1ps
`default_nettype none
module test_cantx_buffer_ctrl
    import cantx_pkg::*;
;
    logic            aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic            s_axi_rvalid, s_axi_rready, irq, go;
    logic [7:0]      s_axi_awaddr, s_axi_araddr;
    logic [31:0]     s_axi_wdata, s_axi_rdata;
    logic [3:0]      s_axi_wstrb, dly;
    logic [1:0]      s_axi_bresp, s_axi_rresp;
    logic [2:0]      tx_send_request, tx_abort_req;
    cantx_sel_s      tx_sel;
    cantx_outcome_s  eng_outcome, cmd;
    logic [33:0]     rq[$];
    logic [1:0]      bq[$];
    int              mismatches, checked, cyc;

    cantx_buffer_ctrl #(.NUM_BUF(3)) cantx_buffer_ctrl_i (.*);
    cantx_engine_model cantx_engine_model_i (.aclk, .aresetn, .go, .cmd, .dly,
        .abort_req(tx_abort_req), .eng_outcome);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] a, input logic [33:0] e);
        checked++;
        if (a !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, a, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int lag;
        // a late bready makes the slave hold its response
        lag = $urandom_range(3, 0);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (lag == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (lag > 0) lag--;
            if (lag == 0) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int lag;
        // a late rready makes the slave hold its read data
        lag = $urandom_range(3, 0);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (lag == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (lag > 0) lag--;
            if (lag == 0) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
    endtask
    // ev order is sent, aborted, arb lost, bus error
    task automatic eng(input logic [3:0] ev, input logic [1:0] i);
        cmd <= {ev, i};
        dly <= 4'($urandom_range(8, 1));
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            cmp(34'(s_axi_bresp), 34'(bq.pop_front()));
        end
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        logic [1:0] p [3];
        int         best;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd, dly} = '0;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        void'($urandom(9699));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 3; i++) rd(8'(4 * i), 32'h0);
        rd(STATUS_OFFS, 32'h0);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h18, 32'h1, RESP_SLVERR);
        wr(8'h00, 32'hff);
        rd(8'h00, 32'h0b);
        wr(8'h04, 32'h09);
        wr(8'h08, 32'h0a);
        repeat (3) @(posedge aclk);
        cmp(34'(tx_sel), 34'h13);
        wr(8'h00, 32'h08);
        repeat (3) @(posedge aclk);
        cmp(34'(tx_sel), 34'h1a);
        rd(8'h00, 32'h08);
        eng(4'b0010, 2'h2);
        rd(8'h08, 32'h2a);
        eng(4'b0001, 2'h2);
        rd(8'h08, 32'h3a);
        eng(4'b1000, 2'h2);
        rd(8'h08, 32'h32);
        eng(4'b0011, 2'h2);
        rd(8'h08, 32'h32);
        cmp(34'(tx_sel), 34'h15);
        wr(8'h04, 32'h01);
        repeat (12) @(posedge aclk);
        rd(8'h04, 32'h41);
        s_axi_wstrb <= 4'he;
        wr(8'h04, 32'h0b);
        s_axi_wstrb <= 4'hf;
        rd(8'h04, 32'h41);
        wr(8'h08, 32'h0b);
        rd(8'h08, 32'h0b);
        cmp(34'(irq), 34'h0);
        wr(MASK_OFFS, 32'hfff);
        repeat (2) @(posedge aclk);
        cmp(34'(irq), 34'h1);
        rd(STATUS_OFFS, 32'hd20);
        repeat (2) @(posedge aclk);
        cmp(34'(irq), 34'h0);
        for (int n = 0; n < 6; n++) begin
            best = 0;
            for (int i = 0; i < 3; i++) begin
                p[i] = 2'($urandom);
                wr(8'(4 * i), {28'h0, 2'b10, p[i]});
                if (p[i] >= p[best]) best = i;
            end
            repeat (3) @(posedge aclk);
            cmp(34'(tx_sel), {1'b1, 2'(best), p[best]});
        end
        end_sim();
    end
endmodule // test_cantx_buffer_ctrl
`default_nettype wire
